// *** design/led_dim_update_period_select.sv ***
// Module: dimming update-period registers and update strobes for LED channels 4..9
// How it works
// - Each channel's code 0..5 yields a duty-cycle update every 1,2,4,8,16 or 32 PWM periods.
// - Codes 6 and 7 behave as code 5, one update every 32 PWM periods.
// - Intervals count PWM periods of 8,192 cycles by default, length set by bits 3:2 at 0x02.
// - Register 0x32 holds channel 6 in bits 10:8, channel 5 in 6:4 and channel 4 in 2:0.
// - Register 0x33 holds channel 9 in bits 10:8, channel 8 in 6:4 and channel 7 in 2:0.
// - Both registers are read/write, read back last written codes and reset to zero.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module led_dim_update_period_select
   import led_dim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NUM_CH-1:0] update_tick,
   output logic [NUM_CH*CODE_W-1:0] update_code,
   output logic pwm_period_end
);
   logic [REG_W-1:0] upd654_r;
   logic [REG_W-1:0] upd987_r;
   logic [PERIOD_SEL_W-1:0] period_sel_r;
   logic [PWM_CNT_W-1:0] pwm_cnt_r;
   logic [DATA_W-1:0] rdata_r;
   logic ack_r;
   logic [PWM_CNT_W-1:0] period_len;
   logic [DATA_W-1:0] be_mask;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] rdata_nxt;
   logic sel_cfg;
   logic sel_654;
   logic sel_987;
   logic req;
   logic wr_go;
   logic [NUM_CH-1:0] tick_w;

   // Byte address is index times four; low two bits must be zero
   assign sel_cfg = (avs_address == {IDX_PERIOD_CFG[ADDR_W-3:0], 2'b00});
   assign sel_654 = (avs_address == {IDX_UPD_654[ADDR_W-3:0], 2'b00});
   assign sel_987 = (avs_address == {IDX_UPD_987[ADDR_W-3:0], 2'b00});
   assign req = avs_read | avs_write;
   // One wait cycle: answer lands on the second edge of the request
   assign avs_waitrequest = req & ~ack_r;
   assign wr_go = avs_write & ack_r;
   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wmask = be_mask & DATA_W'(UPD_RW_MASK);
   // Unmapped addresses read zero and drop writes
   assign rdata_nxt = sel_654 ? DATA_W'(upd654_r) :
                      sel_987 ? DATA_W'(upd987_r) :
                      sel_cfg ? DATA_W'({period_sel_r, 2'b00}) : '0;
   assign period_len = (period_sel_r == 2'd0) ? PERIOD_CYC_0 :
                       (period_sel_r == 2'd1) ? PERIOD_CYC_1 :
                       (period_sel_r == 2'd2) ? PERIOD_CYC_2 : PERIOD_CYC_3;
   assign pwm_period_end = (pwm_cnt_r == period_len - 1'b1);
   assign update_code = {upd987_r[FLD2_LSB +: CODE_W], upd987_r[FLD1_LSB +: CODE_W],
                         upd987_r[FLD0_LSB +: CODE_W], upd654_r[FLD2_LSB +: CODE_W],
                         upd654_r[FLD1_LSB +: CODE_W], upd654_r[FLD0_LSB +: CODE_W]};
   assign update_tick = tick_w;
   assign avs_readdata = rdata_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= req & ~ack_r;
         rdata_r <= (avs_read & ~ack_r) ? rdata_nxt : rdata_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         upd654_r <= UPD_RST;
         upd987_r <= UPD_RST;
         period_sel_r <= PERIOD_SEL_RST;
      end else if (wr_go) begin
         if (sel_654) begin
            upd654_r <= (upd654_r & ~wmask[REG_W-1:0]) |
                        (avs_writedata[REG_W-1:0] & wmask[REG_W-1:0]);
         end
         if (sel_987) begin
            upd987_r <= (upd987_r & ~wmask[REG_W-1:0]) |
                        (avs_writedata[REG_W-1:0] & wmask[REG_W-1:0]);
         end
         if (sel_cfg && avs_byteenable[0]) begin
            period_sel_r <= avs_writedata[PERIOD_SEL_LSB +: PERIOD_SEL_W];
         end
      end
   end

   // Shrinking the period wraps the counter rather than running it out to 2^16
   always_ff @(posedge clk_sys) begin
      if (rst || pwm_period_end || pwm_cnt_r >= period_len) begin
         pwm_cnt_r <= '0;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         led_update_tick u_tick (
            .clk_sys(clk_sys),
            .rst(rst),
            .period_end(pwm_period_end),
            .code(update_code[g*CODE_W +: CODE_W]),
            .update_tick(tick_w[g])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// *** design/led_dim_pkg.sv ***
// Package: register map, field layout and timing constants for dimming update periods
package led_dim_pkg;
   localparam int NUM_CH = 6;
   localparam int CODE_W = 3;
   localparam int REG_W = 13;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_PERIOD_CFG = 8'h02;
   localparam logic [ADDR_W-1:0] IDX_UPD_654 = 8'h32;
   localparam logic [ADDR_W-1:0] IDX_UPD_987 = 8'h33;
   localparam int PERIOD_SEL_LSB = 2;
   localparam int PERIOD_SEL_W = 2;
   localparam logic [PERIOD_SEL_W-1:0] PERIOD_SEL_RST = 2'h0;
   localparam int FLD0_LSB = 0;
   localparam int FLD1_LSB = 4;
   localparam int FLD2_LSB = 8;
   localparam logic [REG_W-1:0] UPD_RW_MASK = 13'h0777;
   localparam logic [REG_W-1:0] UPD_RST = 13'h0000;
   localparam logic [CODE_W-1:0] CODE_MAX = 3'h5;
   // PWM period lengths in clock cycles per period-select value
   localparam int PWM_CNT_W = 16;
   localparam int PERIOD_DEFAULT_CYC = 8192;
   localparam logic [PWM_CNT_W-1:0] PERIOD_CYC_0 = 16'(PERIOD_DEFAULT_CYC);
   localparam logic [PWM_CNT_W-1:0] PERIOD_CYC_1 = 16'h1000;
   localparam logic [PWM_CNT_W-1:0] PERIOD_CYC_2 = 16'h0800;
   localparam logic [PWM_CNT_W-1:0] PERIOD_CYC_3 = 16'h0400;
   localparam int DIV_W = 5;
endpackage

// *** design/led_update_tick.sv ***
// Module: per-channel update strobe divider counting PWM periods
`timescale 1ns/10ps
`default_nettype none
module led_update_tick
   import led_dim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic period_end,
   input wire logic [CODE_W-1:0] code,
   output logic update_tick
);
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] div_nxt;
   logic [CODE_W-1:0] eff_code;
   logic [DIV_W-1:0] terminal;

   // Codes above the top value act as the top value
   assign eff_code = (code > CODE_MAX) ? CODE_MAX : code;
   // 1,2,4,8,16,32 periods per update
   assign terminal = DIV_W'((1 << eff_code) - 1);
   // Stale count above a shrunk terminal wraps at once instead of overrunning
   assign div_nxt = (div_r >= terminal) ? '0 : div_r + 1'b1;
   assign update_tick = period_end && (div_r >= terminal);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_r <= '0;
      end else if (period_end) begin
         div_r <= div_nxt;
      end
   end
endmodule
`default_nettype wire

// *** dv/led_dim_chk.sv ***
// Checker: port assertions for the update-period block
`timescale 1ns/10ps
`default_nettype none
module led_dim_chk
   import led_dim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_CH-1:0] update_tick,
   input wire logic [NUM_CH*CODE_W-1:0] update_code,
   input wire logic pwm_period_end
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
   wire logic rd_ok = avs_read && !avs_waitrequest;
   AST_TICK_ON_END: assert property (update_tick != 6'h0 |-> pwm_period_end)
      else $error("update strobe outside a period end");
   AST_CODE0_EVERY: assert property (
      pwm_period_end && update_code[2:0] == 3'h0 |-> update_tick[0])
      else $error("code zero missed a period end");
   AST_SLOW_GAP: assert property (
      update_tick[5] && update_code[17:15] >= 3'h5 |=> !update_tick[5] [*8])
      else $error("slow channel ticked too soon");
   AST_PERIOD_GAP: assert property (pwm_period_end |=> !pwm_period_end [*8])
      else $error("period end too close");
   AST_REG654: assert property (wr_ok && avs_address == 8'hC8 |=> update_code[8:0] ==
      {$past(avs_writedata[10:8]), $past(avs_writedata[6:4]), $past(avs_writedata[2:0])})
      else $error("low register codes wrong");
   AST_REG987: assert property (wr_ok && avs_address == 8'hCC |=> update_code[17:9] ==
      {$past(avs_writedata[10:8]), $past(avs_writedata[6:4]), $past(avs_writedata[2:0])})
      else $error("high register codes wrong");
   AST_READBACK: assert property (rd_ok && avs_address == 8'hCC |-> avs_readdata == {21'h0,
      update_code[17:15], 1'b0, update_code[14:12], 1'b0, update_code[11:9]})
      else $error("readback differs from codes");
   AST_RSVD: assert property (
      rd_ok && avs_address != 8'h08 |-> (avs_readdata & ~32'h0000_0777) == 0)
      else $error("unused bits not zero");
endmodule
bind led_dim_update_period_select led_dim_chk i_led_dim_chk (.clk_sys(clk_sys), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .update_tick(update_tick), .update_code(update_code),
   .pwm_period_end(pwm_period_end));
`default_nettype wire

// *** dv/testbench.sv ***
// Testbench: register access, reset values and strobe spacing
`timescale 1ns/10ps
`default_nettype none
module testbench
   import led_dim_pkg::*;
;
   logic clk_sys = 0, rst = 1, rd = 0, wr = 0, on = 0;
   logic [ADDR_W-1:0] adr = '0;
   logic [DATA_W-1:0] wdat = '0, q, d;
   logic [15:0] lf = 16'h001F;
   wire logic [DATA_W-1:0] rdata;
   wire logic wreq, pend;
   wire logic [NUM_CH-1:0] tick;
   int num_errors = 0, total_checks = 0, n_end = 0, gap = 0, lastgap = 0, cnt [NUM_CH];
   always #50 clk_sys = ~clk_sys;
   led_dim_update_period_select i_led_dim_update_period_select (.clk_sys(clk_sys), .rst(rst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .update_tick(tick), .update_code(), .pwm_period_end(pend));
   always @(posedge clk_sys) begin
      gap <= pend ? 1 : gap + 1;
      if (pend) lastgap <= gap;
      if (pend && on) begin
         n_end <= n_end + 1;
         for (int i = 0; i < NUM_CH; i++) cnt[i] <= cnt[i] + int'(tick[i]);
      end
   end
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Strobes expected in 32 period ends; codes above five saturate
   function automatic int exp_n(input logic [31:0] r, input int s);
      int c;
      c = int'((r >> s) & 32'h7);
      return 32 >> (c > 5 ? 5 : c);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dv);
      int t = 0;
      rd <= !w; wr <= w; adr <= a; wdat <= dv;
      do begin @(posedge clk_sys); t++; end while (wreq !== 1'b0 && t < 50);
      // A slave that never answers ends the run as a failure
      if (wreq !== 1'b0) begin
         num_errors++;
         close_out;
      end else begin
         q = rdata;
         rd <= 0;
         wr <= 0;
         @(posedge clk_sys);
      end
   endtask
   // Mid-run reset also restarts the dividers, so windows align
   task automatic run(input logic [31:0] a, input logic [31:0] b);
      rst <= 1;
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      bus(1, 8'h08, 32'h0000_000C);
      bus(1, 8'hC8, a);
      bus(1, 8'hCC, b);
      do @(posedge clk_sys); while (pend !== 1'b1);
      n_end <= 0; cnt <= '{default: 0}; on <= 1;
      do @(posedge clk_sys); while (n_end < 32);
      on <= 0;
      chk(lastgap, 1024);
      for (int i = 0; i < NUM_CH; i++) begin
         chk(cnt[i], exp_n(i < 3 ? a : b, 4 * (i % 3)));
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      bus(0, 8'hC8, 0); chk(q, 0);
      bus(0, 8'hCC, 0); chk(q, 0);
      for (int k = 0; k < 6; k++) begin
         lf = nx(lf);
         d = {lf, lf};
         bus(1, k[0] ? 8'hCC : 8'hC8, d);
         bus(1, 8'h40, ~d);
         bus(0, 8'h40, 0); chk(q, 0);
         bus(0, k[0] ? 8'hCC : 8'hC8, 0); chk(q, d & 32'h0000_0777);
      end
      // Default period length before any select write; skip the partial first period
      do @(posedge clk_sys); while (pend !== 1'b1);
      do @(posedge clk_sys); while (pend !== 1'b1);
      @(posedge clk_sys);
      chk(lastgap, PERIOD_DEFAULT_CYC);
      run(32'h0000_0210, 32'h0000_0543);
      run(32'h0000_0576, 32'hFFFF_F8F7);
      close_out;
   end
endmodule
`default_nettype wire
